// ===== verilog/adc_ctl_pkg.sv
package adc_ctl_pkg;
    // ---------------------------------------------------------------
    // register pointers and layout
    // ---------------------------------------------------------------
    localparam logic [1:0] PTR_RESULT = 2'h0;
    localparam logic [1:0] PTR_CONFIG = 2'h1;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] CONFIG_RESET = 16'h058b;
    localparam int START_BIT = 15;
    localparam int PAIR_HI = 14;
    localparam int PAIR_LO = 12;
    localparam int GAIN_HI = 11;
    localparam int GAIN_LO = 9;
    localparam int MODE_BIT = 8;
    localparam int RATE_HI = 7;
    localparam int RATE_LO = 5;
    localparam int RSVD4_BIT = 4;
    localparam int PULLUP_BIT = 3;
    localparam int KEY_HI = 2;
    localparam int KEY_LO = 1;
    localparam int RSVD0_BIT = 0;
    localparam logic [1:0] KEY_VALID = 2'h1;
    localparam logic [2:0] GAIN_LOWEST = 3'h6;
    localparam logic [2:0] GAIN_UNDOC = 3'h7;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int TIMEOUT_MS = 28;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int FRAME_SHORT = 16;
    localparam int FRAME_LONG = 32;
    // sample period in clk cycles per rate code (6.25 to 1000 SPS)
    function automatic int rate_period(input logic [2:0] code);
        unique case (code)
            3'h0: rate_period = CLK_HZ / 625 * 100;
            3'h1: rate_period = CLK_HZ * 2 / 25;
            3'h2: rate_period = CLK_HZ / 25;
            3'h3: rate_period = CLK_HZ / 50;
            3'h4: rate_period = CLK_HZ / 100;
            3'h5: rate_period = CLK_HZ / 250;
            3'h6: rate_period = CLK_HZ / 500;
            default: rate_period = CLK_HZ / 1000;
        endcase
    endfunction : rate_period
endpackage : adc_ctl_pkg

// ===== verilog/sample_if.sv
`timescale 1ns/1ps
// conversion request and result between control and converter timer
interface sample_if;
    logic start;
    logic [2:0] rate;
    logic [15:0] sample;
    logic busy;
    logic done;
    logic [15:0] data;
    modport ctl (output start, output rate, output sample,
                 input busy, input done, input data);
    modport conv (input start, input rate, input sample,
                  output busy, output done, output data);
endinterface : sample_if

// ===== verilog/conv_timer.sv
`timescale 1ns/1ps
module conv_timer
    import adc_ctl_pkg::*;
#(
    parameter int DIV = 1 // shrinks conversion time in simulation
) (
    input wire logic clk,  // system clock
    input wire logic rst_n, // sync reset
    input wire logic ce,   // clock enable
    input wire logic [31:0] scale, // sample period override, 0 = rate
    sample_if.conv sif     // converter side
);
    // refuse a divider that would make the period zero or negative
    if (DIV < 1) begin : g_bad_div
        $error("conv_timer: DIV must be positive");
    end

    logic [31:0] cnt, next_cnt;
    logic busy_q, next_busy;
    logic done_q, next_done;
    logic [15:0] data_q, next_data;

    // count one sample period, then present the front-end sample
    always_comb begin
        next_cnt = cnt;
        next_busy = busy_q;
        next_done = 1'b0;
        next_data = data_q;
        if (!busy_q && sif.start) begin
            next_busy = 1'b1;
            next_cnt = (scale != 32'h0000_0000) ? scale :
                32'(rate_period(sif.rate) / DIV);
        end else if (busy_q) begin
            if (cnt <= 32'h0000_0001) begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_data = sif.sample;
            end else begin
                next_cnt = cnt - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= 32'h0000_0000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            data_q <= RESULT_RESET;
        end else if (ce) begin
            cnt <= next_cnt;
            busy_q <= next_busy;
            done_q <= next_done;
            data_q <= next_data;
        end
    end

    assign sif.busy = busy_q;
    assign sif.done = done_q;
    assign sif.data = data_q;
endmodule : conv_timer

// ===== verilog/adc_serial_ctl.sv
`timescale 1ns/1ps
// Operation
// - result reads zero after reset until first conversion ends
// - result register is 16 bits, read only, never host written
// - start bit starts one conversion only when powered down
// - start bit always reads back as zero
// - three bit input pair select, default code zero
// - three bit gain select, default code two
// - mode bit: zero continuous, one single shot, resets to one
// - three bit rate select, default code four
// - reserved bits ignore writes, bit zero reads one
// - chip select high: pull up if enabled, else float
// - configuration updates only when write key equals 01
// - configuration resets to 058B; pointer 1 config, 0 result
// - mode 1: shift out on rising, sample on falling edge
// - clock low beyond 28 ms resets the serial interface
// - result out msb first while config word shifts in
// - 16 or 32 clock frames, second half echoes config
// - chip select high resets interface and releases output
// - output low while a fresh unread result waits
module adc_serial_ctl
    import adc_ctl_pkg::*;
#(
    parameter int TIMEOUT = TIMEOUT_CYC, // low clock timeout, cycles
    parameter int CONV_DIV = 1           // conversion time divider
) (
    input wire logic clk,            // system clock, 40 MHz
    input wire logic rst_n,          // sync reset, active low
    input wire logic ce,             // clock enable
    input wire logic sclk,           // serial clock pin
    input wire logic cs_n,           // chip select pin, active low
    input wire logic din,            // serial data in pin
    input wire logic [15:0] sample,  // front-end conversion code
    output logic data_out_ready_n,   // data out / ready pin value
    output logic data_out_oe_n,      // low while pin driven
    output logic pullup_on,          // weak pull-up connected
    output logic [2:0] input_pair_select, // front-end input pair
    output logic [2:0] gain_range_select, // effective gain code
    output logic converting          // conversion in progress
);
    // the low clock counter needs at least two cycles to compare against
    if (TIMEOUT < 2) begin : g_bad_timeout
        $error("adc_serial_ctl: TIMEOUT too small");
    end

    // ---------------------------------------------------------------
    // pin synchronisers and edge detect
    // ---------------------------------------------------------------
    logic [1:0] sclk_s, cs_s, din_s;
    logic sclk_d;
    logic rise, fall, sel;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_s <= 2'h0;
            cs_s <= 2'h3;
            din_s <= 2'h0;
            sclk_d <= 1'b0;
        end else if (ce) begin
            sclk_s <= {sclk_s[0], sclk};
            cs_s <= {cs_s[0], cs_n};
            din_s <= {din_s[0], din};
            sclk_d <= sclk_s[1];
        end
    end
    assign sel = !cs_s[1];
    assign rise = sel && sclk_s[1] && !sclk_d;
    assign fall = sel && !sclk_s[1] && sclk_d;

    // ---------------------------------------------------------------
    // converter timer
    // ---------------------------------------------------------------
    sample_if sif ();
    conv_timer #(.DIV(CONV_DIV)) u_conv (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .scale(32'h0000_0000),
        .sif(sif)
    );

    // ---------------------------------------------------------------
    // registers and serial engine
    // ---------------------------------------------------------------
    logic [15:0] result, next_result;
    logic [15:0] cfg, next_cfg;
    logic [15:0] shreg, next_shreg;
    logic [15:0] inreg, next_inreg;
    logic [15:0] echo, next_echo;
    logic [5:0] bitn, next_bitn;
    logic [31:0] lowcnt, next_lowcnt;
    logic fresh, next_fresh;
    logic start_req, next_start_req;
    logic dout, next_dout;
    logic oe_n, next_oe_n;

    // readback view: start bit zero, bit 0 one, bit 4 zero
    function automatic logic [15:0] cfg_view(input logic [15:0] c);
        logic [15:0] v;
        v = c;
        v[START_BIT] = 1'b0;
        v[RSVD4_BIT] = 1'b0;
        v[RSVD0_BIT] = 1'b1;
        return v;
    endfunction : cfg_view

    always_comb begin
        next_result = result;
        next_cfg = cfg;
        next_shreg = shreg;
        next_inreg = inreg;
        next_echo = echo;
        next_bitn = bitn;
        next_lowcnt = lowcnt;
        next_fresh = fresh;
        next_start_req = 1'b0;
        next_dout = dout;
        next_oe_n = oe_n;
        // conversion done loads the result and marks it fresh
        if (sif.done) begin
            next_result = sif.data;
            next_fresh = 1'b1;
        end
        // continuous mode keeps converting; single shot idles
        if (!cfg[MODE_BIT] && !sif.busy && !sif.done) begin
            next_start_req = 1'b1;
        end
        if (!sel) begin
            // deselect resets the interface and releases the pin
            next_bitn = 6'h00;
            next_lowcnt = 32'h0000_0000;
            next_oe_n = 1'b1;
            next_dout = 1'b1;
        end else begin
            next_oe_n = 1'b0;
            if (bitn == 6'h00 && !rise) begin
                next_dout = !fresh;
                next_shreg = result; // lock current result
            end
            if (sclk_s[1] || bitn == 6'h00) begin
                next_lowcnt = 32'h0000_0000;
            end else if (lowcnt >= 32'(TIMEOUT - 1)) begin
                next_bitn = 6'h00;
                next_lowcnt = 32'h0000_0000;
            end else begin
                next_lowcnt = lowcnt + 32'h0000_0001;
            end
            if (rise) begin
                // rising edge presents next bit msb first
                if (bitn < 6'(FRAME_SHORT)) begin
                    next_dout = shreg[15];
                    next_shreg = {shreg[14:0], 1'b0};
                    if (bitn == 6'h00) begin
                        next_fresh = sif.done;
                    end
                end else if (bitn < 6'(FRAME_LONG)) begin
                    next_dout = echo[15];
                    next_echo = {echo[14:0], 1'b0};
                end else begin
                    next_dout = 1'b1;
                end
                next_bitn = (bitn < 6'(FRAME_LONG)) ? bitn + 6'h01 : bitn;
            end
            if (fall && bitn <= 6'(FRAME_SHORT) && bitn != 6'h00) begin
                next_inreg = {inreg[14:0], din_s[1]};
                if (bitn == 6'(FRAME_SHORT)) begin
                    next_echo = cfg_view({inreg[14:0], din_s[1]});
                    if ({inreg[KEY_HI-1:KEY_LO-1]} == KEY_VALID) begin
                        next_cfg = {inreg[14:0], din_s[1]};
                        next_cfg[START_BIT] = 1'b0;
                        next_start_req = inreg[START_BIT-1]
                            && cfg[MODE_BIT] && !sif.busy;
                    end else begin
                        next_echo = cfg_view(cfg);
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result <= RESULT_RESET;
            cfg <= CONFIG_RESET;
            shreg <= RESULT_RESET;
            inreg <= 16'h0000;
            echo <= CONFIG_RESET;
            bitn <= 6'h00;
            lowcnt <= 32'h0000_0000;
            fresh <= 1'b0;
            start_req <= 1'b0;
            dout <= 1'b1;
            oe_n <= 1'b1;
        end else if (ce) begin
            result <= next_result;
            cfg <= next_cfg;
            shreg <= next_shreg;
            inreg <= next_inreg;
            echo <= next_echo;
            bitn <= next_bitn;
            lowcnt <= next_lowcnt;
            fresh <= next_fresh;
            start_req <= next_start_req;
            dout <= next_dout;
            oe_n <= next_oe_n;
        end
    end

    assign sif.start = start_req;
    assign sif.rate = cfg[RATE_HI:RATE_LO];
    assign sif.sample = sample;

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_out_ready_n <= 1'b1;
            data_out_oe_n <= 1'b1;
            pullup_on <= 1'b1;
            input_pair_select <= CONFIG_RESET[PAIR_HI:PAIR_LO];
            gain_range_select <= CONFIG_RESET[GAIN_HI:GAIN_LO];
            converting <= 1'b0;
        end else if (ce) begin
            data_out_ready_n <= dout;
            data_out_oe_n <= oe_n;
            pullup_on <= oe_n && cfg[PULLUP_BIT];
            input_pair_select <= cfg[PAIR_HI:PAIR_LO];
            gain_range_select <= (cfg[GAIN_HI:GAIN_LO] == GAIN_UNDOC) ?
                GAIN_LOWEST : cfg[GAIN_HI:GAIN_LO];
            converting <= sif.busy;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    key_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg != $past(cfg)) |-> ($past(fall)
            && $past(inreg[KEY_HI-1:KEY_LO-1]) == KEY_VALID))
        else $error("config changed without valid key");
    // echo is shifted later, so check it only where it is loaded
    start_reads_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && fall && bitn == 6'(FRAME_SHORT)) |=>
            (echo[START_BIT] == 1'b0 && echo[RSVD4_BIT] == 1'b0))
        else $error("start bit read back as one");
    bit0_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && fall && bitn == 6'(FRAME_SHORT)) |=> echo[RSVD0_BIT] == 1'b1)
        else $error("reserved bit zero not one");
    deselect_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!sel && ce) |=> ##1 data_out_oe_n)
        else $error("pin driven while deselected");
    pullup_a: assert property (@(posedge clk) disable iff (!rst_n)
        (pullup_on |-> data_out_oe_n))
        else $error("pull-up while driving");
    gain_a: assert property (@(posedge clk) disable iff (!rst_n)
        gain_range_select != GAIN_UNDOC)
        else $error("undocumented gain code passed on");
    result_a: assert property (@(posedge clk) disable iff (!rst_n)
        (result != $past(result)) |-> $past(sif.done))
        else $error("result changed without conversion");
    oneshot_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sif.done && cfg[MODE_BIT] && ce) |=> !start_req)
        else $error("single shot restarted by itself");
endmodule : adc_serial_ctl

// ===== testbench/spi_host.sv
`timescale 1ns/1ps
// host side of the serial link, mode 1, bit-banged from the system clock
module spi_host (
    input wire logic clk, // system clock
    input wire logic pin, // resolved data out / ready line
    output logic sclk, // serial clock, idle low
    output logic cs_n, // chip select, active low
    output logic din // serial data to the device
);
    // ---------------------------------------------------------------
    // idle levels
    // ---------------------------------------------------------------
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end

    // ---------------------------------------------------------------
    // one frame of n clocks; sclk is held low for gap cycles after stall
    // ---------------------------------------------------------------
    task automatic frame(input int n, input logic [15:0] wr,
                         input int stall, input int gap,
                         output logic rdy, output logic [31:0] rd);
        rd = 32'h0000_0000;
        @(posedge clk) cs_n <= 1'b0;
        repeat (8) @(posedge clk);
        rdy = pin; // ready level before the first clock
        for (int i = 0; i < n; i++) begin
            @(posedge clk) begin
                sclk <= 1'b1;
                din <= wr[15 - (i % 16)];
            end
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            repeat (3) @(posedge clk);
            rd = {rd[30:0], pin};
            if (i == stall) begin
                repeat (gap) @(posedge clk);
            end
        end
        @(posedge clk) cs_n <= 1'b1;
        // keep chip select high long enough to pass the synchroniser
        repeat (4) @(posedge clk);
    endtask : frame
endmodule : spi_host

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import adc_ctl_pkg::*;
    localparam int TMO = 200;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] sample = 16'h8001;
    logic sclk, cs_n, din, pin;
    logic last_drv = 1'b0;
    logic dout, oe_n, pullup_on, converting;
    logic [2:0] pair, gain;
    logic rdy;
    logic [31:0] rd;
    int n_errors = 0;
    int cmp_count = 0;

    // ---------------------------------------------------------------
    // clock, line resolution, device and host
    // ---------------------------------------------------------------
    always #12.5 clk = ~clk;

    // released line: pull-up level, else the inverse of the last bit
    assign pin = !oe_n ? dout : (pullup_on ? 1'b1 : ~last_drv);
    always @(posedge clk) if (!oe_n) last_drv <= dout;

    adc_serial_ctl #(.TIMEOUT(TMO), .CONV_DIV(10000)) dut (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .sclk(sclk), .cs_n(cs_n),
        .din(din), .sample(sample), .data_out_ready_n(dout),
        .data_out_oe_n(oe_n), .pullup_on(pullup_on),
        .input_pair_select(pair), .gain_range_select(gain),
        .converting(converting)
    );

    spi_host host (
        .clk(clk), .pin(pin), .sclk(sclk), .cs_n(cs_n), .din(din)
    );

    // ---------------------------------------------------------------
    // compare and verdict
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic give_verdict;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(32'({pair, gain}), 32'({3'h0, 3'h2}), "reset fields");
        chk(32'({oe_n, pullup_on, converting}), 32'h3 << 1, "pins");
        // full frame before any conversion: zero result, reset config
        host.frame(32, 16'h0000, 99, 0, rdy, rd);
        chk(32'(rdy), 32'h0000_0001, "idle ready");
        chk(rd, {RESULT_RESET, CONFIG_RESET}, "reset frame");
        // short write: start, pair 5, gain 7, rate 7, reserved bit 4 set, bit 0 clear, no pull-up
        host.frame(16, 16'hdff2, 99, 0, rdy, rd);
        repeat (8) @(posedge clk);
        chk(32'({pair, gain}), 32'({3'h5, GAIN_LOWEST}), "fields");
        chk(32'({oe_n, pullup_on}), 32'h0000_0002, "released");
        repeat (50) @(posedge clk);
        chk(32'(converting), 32'h0000_0000, "power down");
        // read the single conversion, echo of the written word
        host.frame(32, 16'h0000, 99, 0, rdy, rd);
        chk(32'(rdy), 32'h0000_0000, "fresh ready");
        chk(rd, 32'h8001_5fe3, "single shot read");
        repeat (100) @(posedge clk);
        host.frame(32, 16'h0000, 99, 0, rdy, rd);
        chk(32'(rdy), 32'h0000_0001, "no new result");
        chk(rd, 32'h8001_5fe3, "stale read");
        // continuous mode at the fastest rate with pull-up back on
        sample <= 16'h1234;
        host.frame(32, 16'h04eb, 99, 0, rdy, rd);
        chk(rd, 32'h8001_04eb, "echo in frame");
        repeat (100) @(posedge clk);
        chk(32'(pullup_on), 32'h0000_0001, "pull-up on");
        // bad key leaves pair select and config alone
        host.frame(32, 16'h74ef, 99, 0, rdy, rd);
        chk(32'(rdy), 32'h0000_0000, "continuous ready");
        chk(rd, 32'h1234_04eb, "bad key echo");
        chk(32'(pair), 32'h0000_0000, "pair kept");
        // long low clock mid-frame restarts the bit count
        host.frame(37, 16'h0000, 4, TMO + 50, rdy, rd);
        chk(rd, 32'h1234_04eb, "after timeout");
        give_verdict();
    end
endmodule : tb
